// File: design/tcsl_pkg.sv
package tcsl_pkg;
   // Clock and bus-timing figures
   localparam int CLK_MHZ  = 250;
   localparam int HALF_NS  = 80;
   localparam int HALF_CYC = (HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W    = 8;
   localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(HALF_CYC);
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

   // Register addresses
   localparam logic [7:0] ADDR_CTRL    = 8'hC0;
   localparam logic [7:0] ADDR_IRQ_ST  = 8'hC1;
   localparam logic [7:0] ADDR_IRQ_MSK = 8'hC2;
   localparam logic [7:0] ADDR_PM_HIGH = 8'hC3;
   localparam logic [7:0] ADDR_PM_LOW  = 8'hC4;
   localparam logic [7:0] ADDR_LATCH   = 8'hC5;

   // Control register layout
   localparam int CTRL_EN  = 6;
   localparam int CTRL_STA = 5;
   localparam int CTRL_STO = 4;
   localparam int CTRL_SI  = 3;
   localparam int CTRL_AA  = 2;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] CTRL_WMASK = 8'h7C;

   // Interrupt status layout
   localparam int IRQ_W     = 3;
   localparam int IRQ_START = 0;
   localparam int IRQ_STOP  = 1;
   localparam int IRQ_BYTE  = 2;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

   // Pin mode and latch layout: bit 1 data pin, bit 0 clock pin
   localparam int PIN_SDA = 1;
   localparam int PIN_SCL = 0;
   localparam logic [1:0] PM_RST   = 2'h0;
   localparam logic [1:0] PM_OD    = 2'h3;
   localparam logic [1:0] LATCH_RST = 2'h3;

   localparam logic [3:0] ACK_BIT  = 4'h8;
   localparam logic [3:0] BIT_ZERO = 4'h0;

   typedef enum logic [3:0] {
      ST_IDLE, ST_WAIT, ST_START, ST_HOLD, ST_LOW, ST_HIGH,
      ST_STOP_A, ST_STOP_B, ST_STOP_C, ST_RS_A, ST_RS_B
   } tcsl_state_type;
endpackage

// File: design/tcsl_bus_if.sv
`timescale 1ns/1ps
interface tcsl_bus_if;
   logic sda_s;
   logic scl_s;
   logic start_det;
   logic stop_det;
   logic busy;
   modport mon (output sda_s, scl_s, start_det, stop_det, busy);
   modport ctl (input  sda_s, scl_s, start_det, stop_det, busy);
endinterface

// File: design/tcsl_bus_mon.sv
`timescale 1ns/1ps
module tcsl_bus_mon
   import tcsl_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic arst_n_i,
   input  wire logic en_i,
   input  wire logic sda_i,
   input  wire logic scl_i,
   tcsl_bus_if.mon   bus
);
   logic sda_m_r;
   logic scl_m_r;
   logic sda_s_r;
   logic scl_s_r;
   logic sda_p_r;
   logic scl_p_r;
   logic start_r;
   logic stop_r;
   logic busy_r;
   wire  start_nxt;
   wire  stop_nxt;

   // First stage feeds only the second stage
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sda_m_r <= 1'b1;
         scl_m_r <= 1'b1;
         sda_s_r <= 1'b1;
         scl_s_r <= 1'b1;
         sda_p_r <= 1'b1;
         scl_p_r <= 1'b1;
      end else begin
         sda_m_r <= sda_i;
         scl_m_r <= scl_i;
         sda_s_r <= sda_m_r;
         scl_s_r <= scl_m_r;
         sda_p_r <= sda_s_r;
         scl_p_r <= scl_s_r;
      end
   end

   // Data edge while clock stays high
   assign start_nxt = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;
   assign stop_nxt  = scl_s_r & scl_p_r & ~sda_p_r & sda_s_r;

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         start_r <= 1'b0;
         stop_r  <= 1'b0;
         busy_r  <= 1'b0;
      end else begin
         start_r <= start_nxt;
         stop_r  <= stop_nxt;
         busy_r  <= en_i & (start_nxt | (busy_r & ~stop_nxt));
      end
   end

   assign bus.sda_s     = sda_s_r;
   assign bus.scl_s     = scl_s_r;
   assign bus.start_det = start_r;
   assign bus.stop_det  = stop_r;
   assign bus.busy      = busy_r;

   AST_BUSY_ON_START: assert property (@(posedge clock_i)
      disable iff (!arst_n_i) start_r && en_i |-> busy_r)
      else $error("busy not set after start");
   AST_FREE_ON_STOP: assert property (@(posedge clock_i)
      disable iff (!arst_n_i) stop_r |-> !busy_r)
      else $error("busy not cleared after stop");
endmodule

// File: design/tcsl_top.sv
`timescale 1ns/1ps
// What this block does
// - Control register at C0, resets to zero
// - Enable bit off keeps bus logic idle
// - Enabling sets open-drain pins and mode registers
// - Start request on free bus sends START
// - Busy bus: wait for STOP, then START
// - Start request after a byte: repeated START
// - Start request never cleared by hardware
// - Start request writable at any time
// - Stop request while master sends STOP, cleared when seen; cleared unsent when not master
// - Event flag set holds clock line low
// - Ack assert pulls data low on ack clock
module tcsl_top
   import tcsl_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       arst_n_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   output logic            irq_o,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic       scl_i,
   output logic            scl_o,
   output logic            scl_oe_o
);
   tcsl_bus_if bus ();

   tcsl_state_type   state_r;
   tcsl_state_type   state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [3:0]       bit_r;
   logic             en_r;
   logic             sta_r;
   logic             sto_r;
   logic             si_r;
   logic             aa_r;
   logic             master_r;
   logic             bytes_r;
   logic [IRQ_W-1:0] stat_r;
   logic [IRQ_W-1:0] mask_r;
   logic [1:0]       pm_hi_r;
   logic [1:0]       pm_lo_r;
   logic [1:0]       latch_r;
   logic [7:0]       rdata_r;
   logic             irq_r;
   logic             sda_oe_r;
   logic             scl_oe_r;
   logic             pin_lvl_r;

   wire             wr_ctrl;
   wire             rd_stat;
   wire [7:0]       ctrl_val;
   wire [7:0]       rd_mux;
   wire             cnt_done;
   wire             cnt_run;
   wire             scl_pull;
   wire             sda_pull;
   wire             enter_hold;
   wire             start_sent;
   wire             byte_done;
   wire [IRQ_W-1:0] stat_set;
   wire [IRQ_W-1:0] stat_nxt;

   tcsl_bus_mon u_mon (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .en_i     (en_r),
      .sda_i    (sda_i),
      .scl_i    (scl_i),
      .bus      (bus)
   );

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction

   assign wr_ctrl  = wr_i & hit(addr_i, ADDR_CTRL);
   assign rd_stat  = rd_i & hit(addr_i, ADDR_IRQ_ST);
   // Reserved bits 7, 1, 0 are never stored
   assign ctrl_val = {1'b0, en_r, sta_r, sto_r, si_r, aa_r, 2'b00};
   assign rd_mux   = hit(addr_i, ADDR_CTRL)    ? ctrl_val :
                     hit(addr_i, ADDR_IRQ_ST)  ? {5'h00, stat_r} :
                     hit(addr_i, ADDR_IRQ_MSK) ? {5'h00, mask_r} :
                     hit(addr_i, ADDR_PM_HIGH) ? {6'h00, pm_hi_r} :
                     hit(addr_i, ADDR_PM_LOW)  ? {6'h00, pm_lo_r} :
                     hit(addr_i, ADDR_LATCH)   ? {6'h00, latch_r} :
                     8'h00;

   // Half-bit timer, reloads on every state change
   assign cnt_done = (cnt_r == CNT_ZERO);
   // High phases wait for the real clock level so stretching works
   assign cnt_run  = (state_r != ST_HIGH && state_r != ST_STOP_B &&
                      state_r != ST_RS_B) || bus.scl_s;

   assign enter_hold = (state_nxt == ST_HOLD) && (state_r != ST_HOLD);
   assign start_sent = enter_hold && (state_r == ST_START);
   assign byte_done  = enter_hold && (state_r == ST_HIGH);

   // Next state
   always_comb begin
      state_nxt = state_r;
      if (!en_r) begin
         state_nxt = ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (sta_r) begin
                  state_nxt = bus.busy ? ST_WAIT : ST_START;
               end
            end
            ST_WAIT: begin
               if (!sta_r) begin
                  state_nxt = ST_IDLE;
               end else if (!bus.busy) begin
                  state_nxt = ST_START;
               end
            end
            ST_START: begin
               if (cnt_done) state_nxt = ST_HOLD;
            end
            ST_HOLD: begin
               if (!si_r) begin
                  if (sto_r) begin
                     state_nxt = ST_STOP_A;
                  end else if (sta_r && bytes_r) begin
                     state_nxt = ST_RS_A;
                  end else begin
                     state_nxt = ST_LOW;
                  end
               end
            end
            ST_LOW: begin
               if (cnt_done) state_nxt = ST_HIGH;
            end
            ST_HIGH: begin
               if (cnt_done) begin
                  state_nxt = (bit_r == ACK_BIT) ? ST_HOLD : ST_LOW;
               end
            end
            ST_STOP_A: begin
               if (cnt_done) state_nxt = ST_STOP_B;
            end
            ST_STOP_B: begin
               if (cnt_done) state_nxt = ST_STOP_C;
            end
            ST_STOP_C: begin
               if (cnt_done) state_nxt = ST_IDLE;
            end
            ST_RS_A: begin
               if (cnt_done) state_nxt = ST_RS_B;
            end
            ST_RS_B: begin
               if (cnt_done) state_nxt = ST_START;
            end
         endcase
      end
   end

   // Clock held low through the event flag wait
   assign scl_pull = (state_r == ST_HOLD) || (state_r == ST_LOW) ||
                     (state_r == ST_STOP_A) || (state_r == ST_RS_A);
   // Receiver only; ack pull and release wait for synced clock low
   assign sda_pull = (state_r == ST_START) ||
                     (state_r == ST_HOLD &&
                      (!bytes_r || (aa_r && bus.scl_s))) ||
                     (state_r == ST_STOP_A) || (state_r == ST_STOP_B) ||
                     (((state_r == ST_LOW && !bus.scl_s) ||
                       state_r == ST_HIGH) &&
                      bit_r == ACK_BIT && aa_r);

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= ST_IDLE;
         cnt_r   <= HALF_CNT;
         bit_r   <= BIT_ZERO;
      end else begin
         state_r <= state_nxt;
         if (state_nxt != state_r) begin
            cnt_r <= HALF_CNT;
         end else if (!cnt_done && cnt_run) begin
            cnt_r <= cnt_r - 8'h01;
         end
         if (state_r == ST_HOLD) begin
            bit_r <= BIT_ZERO;
         end else if (state_r == ST_HIGH && state_nxt == ST_LOW) begin
            bit_r <= bit_r + 4'h1;
         end
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         master_r <= 1'b0;
         bytes_r  <= 1'b0;
      end else begin
         if (!en_r || state_nxt == ST_IDLE) begin
            master_r <= 1'b0;
         end else if (start_sent) begin
            master_r <= 1'b1;
         end
         if (start_sent || state_nxt == ST_IDLE) begin
            bytes_r <= 1'b0;
         end else if (byte_done) begin
            bytes_r <= 1'b1;
         end
      end
   end

   // Control register; hardware sets win over software clears
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         en_r  <= CTRL_RST[CTRL_EN];
         sta_r <= CTRL_RST[CTRL_STA];
         sto_r <= CTRL_RST[CTRL_STO];
         si_r  <= CTRL_RST[CTRL_SI];
         aa_r  <= CTRL_RST[CTRL_AA];
      end else begin
         if (wr_ctrl) begin
            en_r  <= wdata_i[CTRL_EN];
            sta_r <= wdata_i[CTRL_STA];
            aa_r  <= wdata_i[CTRL_AA];
         end
         if (wr_ctrl && wdata_i[CTRL_STO]) begin
            sto_r <= 1'b1;
         end else if (bus.stop_det || !master_r) begin
            sto_r <= 1'b0;
         end
         if (enter_hold) begin
            si_r <= 1'b1;
         end else if (wr_ctrl && !wdata_i[CTRL_SI]) begin
            si_r <= 1'b0;
         end
      end
   end

   // Enabling forces open-drain mode codes on both pins
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pm_hi_r <= PM_RST;
         pm_lo_r <= PM_RST;
         latch_r <= LATCH_RST;
         mask_r  <= IRQ_RST;
      end else begin
         if (wr_ctrl && wdata_i[CTRL_EN] && !en_r) begin
            pm_hi_r <= PM_OD;
            pm_lo_r <= PM_OD;
         end else begin
            if (wr_i && hit(addr_i, ADDR_PM_HIGH)) pm_hi_r <= wdata_i[1:0];
            if (wr_i && hit(addr_i, ADDR_PM_LOW))  pm_lo_r <= wdata_i[1:0];
         end
         if (wr_i && hit(addr_i, ADDR_LATCH)) latch_r <= wdata_i[1:0];
         if (wr_i && hit(addr_i, ADDR_IRQ_MSK)) begin
            mask_r <= wdata_i[IRQ_W-1:0];
         end
      end
   end

   // Read clears status; an event in that cycle survives
   assign stat_set = {byte_done, bus.stop_det, start_sent};
   assign stat_nxt = (rd_stat ? IRQ_RST : stat_r) | stat_set;

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stat_r  <= IRQ_RST;
         irq_r   <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         stat_r  <= stat_nxt;
         irq_r   <= |(stat_r & mask_r);
         rdata_r <= rd_i ? rd_mux : 8'h00;
      end
   end

   // Latch low keeps a pin pulled, so latches must be one first
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sda_oe_r  <= 1'b0;
         scl_oe_r  <= 1'b0;
         pin_lvl_r <= 1'b0;
      end else begin
         sda_oe_r  <= en_r & (sda_pull | ~latch_r[PIN_SDA]);
         scl_oe_r  <= en_r & (scl_pull | ~latch_r[PIN_SCL]);
         pin_lvl_r <= 1'b0;
      end
   end

   assign rdata_o  = rdata_r;
   assign irq_o    = irq_r;
   assign sda_o    = pin_lvl_r;
   assign scl_o    = pin_lvl_r;
   assign sda_oe_o = sda_oe_r;
   assign scl_oe_o = scl_oe_r;

   AST_CTRL_READ: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      rd_i && hit(addr_i, ADDR_CTRL) |=> rdata_o == $past(ctrl_val))
      else $error("control read mismatch");
   AST_RSVD_ZERO: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      rd_i && hit(addr_i, ADDR_CTRL) |=> rdata_o[7] == 1'b0 &&
      rdata_o[1:0] == 2'b00)
      else $error("reserved bits not zero");
   AST_DISABLED_IDLE: assert property (@(posedge clock_i)
      disable iff (!arst_n_i)
      !en_r |=> !sda_oe_o && !scl_oe_o && state_r == ST_IDLE)
      else $error("bus driven while disabled");
   AST_ENABLE_OD: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      wr_ctrl && wdata_i[CTRL_EN] && !en_r |=>
      pm_hi_r == PM_OD && pm_lo_r == PM_OD)
      else $error("pin mode not open drain");
   AST_START_FREE: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      state_r == ST_IDLE && en_r && sta_r && !bus.busy |=>
      state_r == ST_START ##1 sda_oe_o)
      else $error("no start on free bus");
   AST_WAIT_BUSY: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      state_r == ST_WAIT && en_r && sta_r && bus.busy |=>
      state_r == ST_WAIT)
      else $error("left wait while busy");
   AST_REP_START: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      state_r == ST_HOLD && en_r && !si_r && !sto_r && sta_r && bytes_r
      |=> state_r == ST_RS_A)
      else $error("no repeated start");
   AST_STA_KEPT: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      sta_r && !wr_ctrl |=> sta_r)
      else $error("start request cleared by hardware");
   AST_STA_WRITE: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      wr_ctrl |=> sta_r == $past(wdata_i[CTRL_STA]))
      else $error("start request write lost");
   AST_STO_CLEAR: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      sto_r && bus.stop_det && !wr_ctrl |=> !sto_r)
      else $error("stop request not cleared");
   AST_SI_HOLDS: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      si_r && en_r && state_r == ST_HOLD |=> scl_oe_o)
      else $error("clock not held during event flag");
   AST_ACK_LOW: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      state_r == ST_HIGH && bit_r == ACK_BIT && aa_r && en_r |=>
      sda_oe_o)
      else $error("ack not driven");

   COV_START: cover property (@(posedge clock_i) disable iff (!arst_n_i)
      start_sent);
   COV_WAIT: cover property (@(posedge clock_i) disable iff (!arst_n_i)
      state_r == ST_WAIT ##1 state_r == ST_START);
   COV_REP: cover property (@(posedge clock_i) disable iff (!arst_n_i)
      state_r == ST_RS_B ##1 state_r == ST_START);
   COV_STOP: cover property (@(posedge clock_i) disable iff (!arst_n_i)
      state_r == ST_STOP_C ##1 state_r == ST_IDLE);
endmodule

// File: verification/tcsl_bus_peer.sv
`timescale 1ns/1ps
module tcsl_bus_peer (
   input  wire logic scl_w_i,
   input  wire logic stretch_i,
   output logic      sda_oe_o,
   output logic      scl_oe_o
);
   logic frame_oe_r;
   logic stretch_oe_r;

   initial begin
      sda_oe_o     = 1'b0;
      frame_oe_r   = 1'b0;
      stretch_oe_r = 1'b0;
   end

   assign scl_oe_o = frame_oe_r | stretch_oe_r;

   // Slow target: keeps the clock low a while after each fall
   always @(negedge scl_w_i) begin
      if (stretch_i) begin
         stretch_oe_r = 1'b1;
         #200 stretch_oe_r = 1'b0;
      end
   end

   // Foreign master: data falls while clock is high, clock then held low
   task automatic foreign_start();
      sda_oe_o = 1'b1;
      #80 frame_oe_r = 1'b1;
   endtask

   // Clock released first so data rises while clock is high
   task automatic foreign_stop();
      #80 frame_oe_r = 1'b0;
      #80 sda_oe_o = 1'b0;
   endtask
endmodule

// File: verification/tcsl_top_tb.sv
`timescale 1ns/1ps
module tcsl_top_tb;
   import tcsl_pkg::*;
   logic       clock_i;
   logic       arst_n_i;
   logic [7:0] addr_i;
   logic [7:0] wdata_i;
   logic       wr_i;
   logic       rd_i;
   logic [7:0] rdata_o;
   logic       irq_o;
   logic       sda_o;
   logic       sda_oe_o;
   logic       scl_o;
   logic       scl_oe_o;
   logic       peer_sda_oe;
   logic       peer_scl_oe;
   logic       stretch;
   logic       last_sda;
   wire        sda_w;
   wire        scl_w;
   int         n_start = 0;
   int         n_stop = 0;
   int         n_rise = 0;
   int         miscompares = 0;
   int         cmp_count = 0;

   // Pull-ups: the wire is low while any party pulls it
   assign sda_w = ~(sda_oe_o | peer_sda_oe);
   assign scl_w = ~(scl_oe_o | peer_scl_oe);

   always @(negedge sda_w) if (scl_w === 1'b1) n_start++;
   always @(posedge sda_w) if (scl_w === 1'b1) n_stop++;
   always @(posedge scl_w) begin
      n_rise++;
      last_sda = sda_w;
   end

   tcsl_top DUT (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .addr_i   (addr_i),
      .wdata_i  (wdata_i),
      .wr_i     (wr_i),
      .rd_i     (rd_i),
      .rdata_o  (rdata_o),
      .irq_o    (irq_o),
      .sda_i    (sda_w),
      .sda_o    (sda_o),
      .sda_oe_o (sda_oe_o),
      .scl_i    (scl_w),
      .scl_o    (scl_o),
      .scl_oe_o (scl_oe_o)
   );

   tcsl_bus_peer peer (
      .scl_w_i   (scl_w),
      .stretch_i (stretch),
      .sda_oe_o  (peer_sda_oe),
      .scl_oe_o  (peer_scl_oe)
   );

   task automatic check(input string what, input logic [7:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, d);
      @(posedge clock_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clock_i);
      wr_i    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clock_i);
      rd_i   <= 1'b0;
      #1 d = rdata_o;
   endtask

   // Bounded wait on control bits; a stuck machine counts as a mismatch
   task automatic poll(input logic [7:0] m, v);
      logic [7:0] d;
      for (int i = 0; i < 2000; i++) begin
         rd_reg(ADDR_CTRL, d);
         if ((d & m) === v) return;
      end
      check("poll timeout", d & m, v);
   endtask

   task automatic do_stop();
      wr_reg(ADDR_CTRL, 8'h50);
      poll(8'h10, 8'h00);
   endtask

   task automatic test_reset();
      logic [7:0] d;
      rd_reg(ADDR_CTRL, d);
      check("ctrl reset", d, CTRL_RST);
      wr_reg(ADDR_CTRL, 8'h83);
      rd_reg(ADDR_CTRL, d);
      check("ctrl reserved", d, 8'h00);
      check("oe disabled", {6'h00, sda_oe_o, scl_oe_o}, 8'h00);
      rd_reg(8'h3F, d);
      check("unmapped", d, 8'h00);
      $display("test_reset done");
   endtask

   task automatic test_enable();
      logic [7:0] d;
      wr_reg(ADDR_LATCH, 8'h03);
      wr_reg(ADDR_IRQ_MSK, 8'h01);
      wr_reg(ADDR_CTRL, 8'h40);
      rd_reg(ADDR_PM_HIGH, d);
      check("mode high", d, {6'h00, PM_OD});
      rd_reg(ADDR_PM_LOW, d);
      check("mode low", d, {6'h00, PM_OD});
      check("oe enabled idle", {6'h00, sda_oe_o, scl_oe_o}, 8'h00);
      $display("test_enable done");
   endtask

   task automatic test_start();
      logic [7:0] d;
      int n0;
      n0 = n_start;
      wr_reg(ADDR_CTRL, 8'h60);
      poll(8'h08, 8'h08);
      rd_reg(ADDR_CTRL, d);
      check("ctrl after start", d, 8'h68);
      check("start on wire", 8'(n_start - n0), 8'h01);
      repeat (100) @(posedge clock_i);
      check("clock held", {7'h00, scl_w}, 8'h00);
      check("pin level", {6'h00, sda_o, scl_o}, 8'h00);
      check("irq raised", {7'h00, irq_o}, 8'h01);
      rd_reg(ADDR_IRQ_ST, d);
      check("status start", d, 8'h01);
      repeat (3) @(posedge clock_i);
      check("irq cleared", {7'h00, irq_o}, 8'h00);
      $display("test_start done");
   endtask

   // Stretching target, ack asserted; byte event is masked out
   task automatic test_byte();
      logic [7:0] d;
      int r0;
      r0 = n_rise;
      stretch <= 1'b1;
      wr_reg(ADDR_CTRL, 8'h44);
      poll(8'h08, 8'h08);
      stretch <= 1'b0;
      check("byte clocks", 8'(n_rise - r0), 8'h09);
      check("ack low", {7'h00, last_sda}, 8'h00);
      check("irq masked", {7'h00, irq_o}, 8'h00);
      rd_reg(ADDR_IRQ_ST, d);
      check("status byte", d, 8'h04);
      $display("test_byte done");
   endtask

   task automatic test_restart_stop();
      logic [7:0] d;
      int n0;
      int p0;
      n0 = n_start;
      wr_reg(ADDR_CTRL, 8'h64);
      poll(8'h08, 8'h08);
      check("repeated start", 8'(n_start - n0), 8'h01);
      p0 = n_stop;
      do_stop();
      check("stop on wire", 8'(n_stop - p0), 8'h01);
      rd_reg(ADDR_CTRL, d);
      check("sto cleared", d & 8'h70, 8'h40);
      rd_reg(ADDR_IRQ_ST, d);
      check("status stop", d, 8'h03);
      $display("test_restart_stop done");
   endtask

   task automatic test_busy();
      logic [7:0] d;
      int n0;
      n0 = n_start;
      peer.foreign_start();
      wr_reg(ADDR_CTRL, 8'h60);
      repeat (200) @(posedge clock_i);
      rd_reg(ADDR_CTRL, d);
      check("sta while busy", d & 8'h60, 8'h60);
      check("waits for stop", {7'h00, sda_oe_o}, 8'h00);
      peer.foreign_stop();
      poll(8'h08, 8'h08);
      check("start after stop", 8'(n_start - n0), 8'h02);
      do_stop();
      wr_reg(ADDR_CTRL, 8'h00);
      repeat (3) @(posedge clock_i);
      check("disabled", {6'h00, sda_oe_o, scl_oe_o}, 8'h00);
      $display("test_busy done");
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   // Roughly fifteen hundred cycles expected; cut off at fifty thousand
   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end

   initial begin
      arst_n_i = 1'b0;
      addr_i   = 8'h00;
      wdata_i  = 8'h00;
      wr_i     = 1'b0;
      rd_i     = 1'b0;
      stretch  = 1'b0;
      repeat (10) @(posedge clock_i);
      arst_n_i <= 1'b1;
      test_reset();
      test_enable();
      test_start();
      test_byte();
      test_restart_stop();
      test_busy();
      give_verdict();
   end
endmodule
